// File: rtl/aoms_defs.svh
// Shared constants of the angle output mode select block
`ifndef AOMS_DEFS_SVH
`define AOMS_DEFS_SVH

// angle code and output level widths
`define AOMS_ANGLE_W      13
`define AOMS_DAC_W        13
`define AOMS_DATA_W       14
`define AOMS_WORD_W       16
`define AOMS_BITCNT_W     5

// serial word layout
`define AOMS_ERR_BIT      13
`define AOMS_HI_DATA_MSB  13
`define AOMS_HI_DATA_LSB  7
`define AOMS_LO_DATA_MSB  6
`define AOMS_LO_DATA_LSB  0
`define AOMS_LAST_BIT     5'h0f
`define AOMS_FRAME_BITS   5'h10

// output levels, full scale is supply
`define AOMS_CLAMP_LO_RST 13'h019a
`define AOMS_CLAMP_HI_RST 13'h1e65
`define AOMS_DIAG_LO      13'h0000
`define AOMS_DIAG_HI      13'h1fff
`define AOMS_CMP_LOW      13'h0000
`define AOMS_CMP_HIGH     13'h1fff
`define AOMS_RST_LEVEL    13'h0000
`define AOMS_THR_RST      13'h1000
`define AOMS_WORD_RST     16'h0000
`define AOMS_ANGLE_RST    13'h0000

`endif

// File: rtl/aoms_pkg.sv
// Types of the angle output mode select block
`default_nettype none
package aoms_pkg;

	typedef enum logic [2:0] {
		mode_serial     = 3'h0,
		mode_serial_cpl = 3'h1,
		mode_rsv_a      = 3'h2,
		mode_rsv_b      = 3'h3,
		mode_inverted   = 3'h4,
		mode_half       = 3'h5,
		mode_comparator = 3'h6,
		mode_hiz        = 3'h7
	} aoms_mode_type;

	typedef enum logic [1:0] {
		err_diag     = 2'h0,
		err_input    = 2'h1,
		err_overtemp = 2'h2,
		err_unused   = 2'h3
	} aoms_err_type;

endpackage : aoms_pkg
`default_nettype wire

// File: rtl/aoms_map_if.sv
// Carrier between the selector and its level mapper
`timescale 1ns/1ps
`default_nettype none
`include "aoms_defs.svh"
interface aoms_map_if;
	logic [`AOMS_DAC_W-1:0] angle;
	logic [`AOMS_DAC_W-1:0] clamp_lo;
	logic [`AOMS_DAC_W-1:0] clamp_hi;
	logic [`AOMS_DAC_W-1:0] std_level;
	logic [`AOMS_DAC_W-1:0] inv_level;
	logic [`AOMS_DAC_W-1:0] half_level;

	modport requester (
		output angle, clamp_lo, clamp_hi,
		input  std_level, inv_level, half_level
	);
	modport mapper (
		input  angle, clamp_lo, clamp_hi,
		output std_level, inv_level, half_level
	);
endinterface : aoms_map_if
`default_nettype wire

// File: rtl/aoms_level_map.sv
// Linear angle to output level mapping for the analog stages
`timescale 1ns/1ps
`default_nettype none
`include "aoms_defs.svh"
module aoms_level_map
	import aoms_pkg::*;
#(
	parameter int WIDTH = `AOMS_DAC_W
) (
	// clock and reset
	input wire logic  mclk,
	input wire logic  rst_n,
	// mapping request and result
	aoms_map_if.mapper map
);
	logic [WIDTH-1:0]   span;
	logic [2*WIDTH-1:0] product;
	logic [WIDTH-1:0]   scaled;
	logic [WIDTH-1:0]   std_sum;

	if (WIDTH != `AOMS_DAC_W) begin : g_width_check
		$error("level map width must match the carrier width");
	end

	always_comb begin
		span    = map.clamp_hi - map.clamp_lo;
		product = {{WIDTH{1'b0}}, map.angle} * {{WIDTH{1'b0}}, span};
		scaled  = product[2*WIDTH-1:WIDTH];
		std_sum = map.clamp_lo + scaled;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			map.std_level  <= `AOMS_RST_LEVEL;
			map.inv_level  <= `AOMS_RST_LEVEL;
			map.half_level <= `AOMS_RST_LEVEL;
		end else begin
			map.std_level  <= std_sum;
			map.inv_level  <= map.clamp_hi - scaled;
			map.half_level <= {1'b0, std_sum[WIDTH-1:1]};
		end
	end
endmodule : aoms_level_map
`default_nettype wire

// File: rtl/aoms_output_select.sv
// Output mode selection, analog stages and serial link of the angle sensor
`timescale 1ns/1ps
`default_nettype none
`include "aoms_defs.svh"
// Overview of operation
// - Both output pins are switched together to analog or serial use by the stored mode field.
// - In analog use the angle becomes a supply-relative level on the primary output and feeds the second stage.
// - A valid angle maps linearly from the low clamp to the high clamp, by default 5% and 95% of supply.
// - The second stage takes exactly one of inverted, half range, comparator or high impedance.
// - Inverted mode puts the high clamp at the low angle end and the low clamp at the high end.
// - Half range mode maps valid angles from half the low clamp to half the high clamp.
// - Comparator mode drives low or high as the angle is below or above the programmed threshold.
// - Outside comparator and half range modes, levels outside the clamp range only ever signal a diagnostic condition.
// - Mode field 100 inverted, 101 half, 110 comparator, 111 high impedance, 000 serial, 001 complemented.
// - The angle is a 13 bit code sent unchanged in serial mode so steps stay monotonic.
// - An edge rate bit picks slow or fast serial data edges, zero giving the fast ones.
// - Offset and configuration words can be written in over the serial interface.
// - The serial word is 14 bits in two bytes, high byte first, each with odd parity over seven bits.
// - An error sets the top data bit and puts the error code into the two lowest bits.
module aoms_output_select
	import aoms_pkg::*;
#(
	parameter int ANGLE_W = `AOMS_ANGLE_W
) (
	// clock and reset
	input  wire logic               mclk,
	input  wire logic               rst_n,
	// angle source
	input  wire logic [ANGLE_W-1:0] angle_code,
	input  wire logic               angle_strobe,
	// diagnosis
	input  wire logic               error_active,
	input  wire logic [1:0]         error_code,
	// stored configuration
	input  wire logic               output_mode_sel_hi,
	input  wire logic               output_mode_sel_mid,
	input  wire logic               output_mode_sel_lo,
	input  wire logic               edge_rate_select,
	input  wire logic [ANGLE_W-1:0] clamp_low_level,
	input  wire logic [ANGLE_W-1:0] clamp_high_level,
	input  wire logic [ANGLE_W-1:0] comp_threshold,
	input  wire logic               prog_enable,
	// analog stages
	output logic      [ANGLE_W-1:0] primary_output_level,
	output logic                    primary_output_oe,
	output logic      [ANGLE_W-1:0] secondary_output_level,
	output logic                    secondary_output_oe,
	output logic                    slow_edge,
	// serial link pins
	input  wire logic               link_clk,
	input  wire logic               cs_n,
	input  wire logic               data_in,
	output logic                    data_out,
	output logic                    data_oe,
	// programming words received
	output logic      [`AOMS_WORD_W-1:0] prog_word,
	output logic                    prog_word_valid
);
	aoms_mode_type               mode_q;
	logic [ANGLE_W-1:0]          angle_q;
	logic [ANGLE_W-1:0]          lo_q;
	logic [ANGLE_W-1:0]          hi_q;
	logic [ANGLE_W-1:0]          thr_q;
	logic                        err_q;
	logic [1:0]                  ecode_q;
	logic                        prog_q;
	logic                        diag_q;
	logic                        out_mapped_q;
	logic                        is_analog;
	logic                        is_serial;
	logic                        sec_drive;
	logic [`AOMS_DATA_W-1:0]     raw_data;
	logic [`AOMS_DATA_W-1:0]     tx_data;
	logic [`AOMS_WORD_W-1:0]     next_word;
	logic                        next_allow;
	logic [`AOMS_WORD_W-1:0]     snap_word;
	logic                        snap_allow;
	logic                        cs_s1;
	logic                        cs_s2;
	logic                        link_busy;
	logic                        tg_s1;
	logic                        tg_s2;
	logic                        tg_s3;
	logic [`AOMS_BITCNT_W-1:0]   tx_cnt;
	logic [`AOMS_BITCNT_W-1:0]   rx_cnt;
	logic [`AOMS_WORD_W-1:0]     rx_shift;
	logic [`AOMS_WORD_W-1:0]     rx_hold;
	logic                        rx_toggle;
	logic [ANGLE_W-1:0]          lo_d1;
	logic [ANGLE_W-1:0]          lo_d2;
	logic [ANGLE_W-1:0]          hi_d1;
	logic [ANGLE_W-1:0]          hi_d2;

	if (ANGLE_W != `AOMS_ANGLE_W) begin : g_width_check
		$error("angle width is fixed by the serial word layout");
	end

	aoms_map_if map_bus ();

	assign map_bus.angle    = angle_q;
	assign map_bus.clamp_lo = lo_q;
	assign map_bus.clamp_hi = hi_q;

	aoms_level_map #(
		.WIDTH (`AOMS_DAC_W)
	) u_map (
		.mclk  (mclk),
		.rst_n (rst_n),
		.map   (map_bus)
	);

	// configuration and angle capture
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q    <= mode_rsv_a;
			lo_q      <= `AOMS_CLAMP_LO_RST;
			hi_q      <= `AOMS_CLAMP_HI_RST;
			thr_q     <= `AOMS_THR_RST;
			prog_q    <= 1'b0;
			slow_edge <= 1'b0;
		end else begin
			mode_q    <= aoms_mode_type'({output_mode_sel_hi,
				output_mode_sel_mid, output_mode_sel_lo});
			lo_q      <= clamp_low_level;
			hi_q      <= clamp_high_level;
			thr_q     <= comp_threshold;
			prog_q    <= prog_enable;
			slow_edge <= edge_rate_select;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			angle_q <= `AOMS_ANGLE_RST;
			err_q   <= 1'b0;
			ecode_q <= err_diag;
		end else begin
			if (angle_strobe) begin
				angle_q <= angle_code;
			end
			err_q   <= error_active;
			ecode_q <= error_code;
		end
	end

	// over-temperature keeps the angle usable
	assign diag_q = err_q && (ecode_q != err_overtemp);

	always_comb begin
		is_analog = 1'b0;
		is_serial = 1'b0;
		sec_drive = 1'b0;
		case (mode_q)
			mode_inverted,
			mode_half,
			mode_comparator: begin
				is_analog = 1'b1;
				sec_drive = 1'b1;
			end
			mode_hiz: begin
				is_analog = 1'b1;
			end
			mode_serial,
			mode_serial_cpl: begin
				is_serial = 1'b1;
			end
			default: begin
				is_analog = 1'b0;
			end
		endcase
	end

	// analog output stages
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			primary_output_level   <= `AOMS_RST_LEVEL;
			primary_output_oe      <= 1'b0;
			secondary_output_level <= `AOMS_RST_LEVEL;
			secondary_output_oe    <= 1'b0;
			out_mapped_q           <= 1'b0;
		end else begin
			primary_output_oe   <= is_analog;
			out_mapped_q        <= !diag_q;
			primary_output_level <= diag_q ? `AOMS_DIAG_LO : map_bus.std_level;
			secondary_output_oe <= sec_drive;
			case (mode_q)
				mode_inverted: begin
					secondary_output_level <= diag_q ? `AOMS_DIAG_HI
						: map_bus.inv_level;
				end
				mode_half: begin
					secondary_output_level <= diag_q ? `AOMS_DIAG_LO
						: map_bus.half_level;
				end
				mode_comparator: begin
					secondary_output_level <= (!diag_q && angle_q >= thr_q)
						? `AOMS_CMP_HIGH : `AOMS_CMP_LOW;
				end
				default: begin
					secondary_output_level <= `AOMS_RST_LEVEL;
				end
			endcase
		end
	end

	always_comb begin
		raw_data = {1'b0, angle_q};
		if (err_q) begin
			raw_data = {1'b1, angle_q[ANGLE_W-1:2], ecode_q};
		end
		tx_data = raw_data;
		if (mode_q == mode_serial_cpl) begin
			tx_data = ~raw_data;
		end
	end

	always_comb begin
		next_word = {tx_data[`AOMS_HI_DATA_MSB:`AOMS_HI_DATA_LSB],
			~^tx_data[`AOMS_HI_DATA_MSB:`AOMS_HI_DATA_LSB],
			tx_data[`AOMS_LO_DATA_MSB:`AOMS_LO_DATA_LSB],
			~^tx_data[`AOMS_LO_DATA_MSB:`AOMS_LO_DATA_LSB]};
		next_allow = is_serial && !prog_q;
	end

	// frame select seen in the system domain
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
		end else begin
			cs_s1 <= cs_n;
			cs_s2 <= cs_s1;
		end
	end

	assign link_busy = !cs_s2;

	// word is frozen while a frame runs; the select setup time is many
	// system cycles, so the link never reads it mid-update
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			snap_word  <= `AOMS_WORD_RST;
			snap_allow <= 1'b0;
		end else if (!link_busy) begin
			snap_word  <= next_word;
			snap_allow <= next_allow;
		end
	end

	// transmit on falling link clock, cleared by the frame select
	always_ff @(negedge link_clk or posedge cs_n) begin
		if (cs_n) begin
			tx_cnt   <= 5'h00;
			data_out <= 1'b0;
			data_oe  <= 1'b0;
		end else begin
			if (tx_cnt != `AOMS_FRAME_BITS) begin
				tx_cnt   <= tx_cnt + 5'h01;
				data_out <= snap_word[~tx_cnt[3:0]];
				data_oe  <= snap_allow;
			end else begin
				data_oe  <= 1'b0;
			end
		end
	end

	// receive words on rising link clock
	always_ff @(posedge link_clk or posedge cs_n) begin
		if (cs_n) begin
			rx_cnt   <= 5'h00;
			rx_shift <= `AOMS_WORD_RST;
		end else begin
			rx_shift <= {rx_shift[`AOMS_WORD_W-2:0], data_in};
			rx_cnt   <= (rx_cnt == `AOMS_LAST_BIT) ? 5'h00 : rx_cnt + 5'h01;
		end
	end

	// toggle survives the frame end, so it resets with the system
	always_ff @(posedge link_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_hold   <= `AOMS_WORD_RST;
			rx_toggle <= 1'b0;
		end else if (!cs_n && rx_cnt == `AOMS_LAST_BIT) begin
			rx_hold   <= {rx_shift[`AOMS_WORD_W-2:0], data_in};
			rx_toggle <= ~rx_toggle;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tg_s1 <= 1'b0;
			tg_s2 <= 1'b0;
			tg_s3 <= 1'b0;
		end else begin
			tg_s1 <= rx_toggle;
			tg_s2 <= tg_s1;
			tg_s3 <= tg_s2;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prog_word       <= `AOMS_WORD_RST;
			prog_word_valid <= 1'b0;
		end else begin
			prog_word_valid <= (tg_s2 ^ tg_s3) && prog_q;
			if ((tg_s2 ^ tg_s3) && prog_q) begin
				prog_word <= rx_hold;
			end
		end
	end

	// clamp history matching the mapper latency
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lo_d1 <= `AOMS_CLAMP_LO_RST;
			lo_d2 <= `AOMS_CLAMP_LO_RST;
			hi_d1 <= `AOMS_CLAMP_HI_RST;
			hi_d2 <= `AOMS_CLAMP_HI_RST;
		end else begin
			lo_d1 <= lo_q;
			lo_d2 <= lo_d1;
			hi_d1 <= hi_q;
			hi_d2 <= hi_d1;
		end
	end

	property p_reserved_quiet;
		@(posedge mclk) disable iff (!rst_n)
		(mode_q == mode_rsv_a || mode_q == mode_rsv_b) |=>
			!primary_output_oe && !secondary_output_oe;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet)
		else $error("reserved mode drives an output");

	property p_serial_no_analog;
		@(posedge mclk) disable iff (!rst_n)
		(mode_q == mode_serial || mode_q == mode_serial_cpl) |=>
			!primary_output_oe && !secondary_output_oe;
	endproperty
	a_serial_no_analog: assert property (p_serial_no_analog)
		else $error("analog stage on in serial mode");

	property p_hiz_second;
		@(posedge mclk) disable iff (!rst_n)
		mode_q == mode_hiz |=> primary_output_oe && !secondary_output_oe;
	endproperty
	a_hiz_second: assert property (p_hiz_second)
		else $error("high impedance mode decoded wrongly");

	property p_prim_range;
		@(posedge mclk) disable iff (!rst_n)
		primary_output_oe && out_mapped_q && lo_d2 <= hi_d2 |->
			primary_output_level >= lo_d2 && primary_output_level <= hi_d2;
	endproperty
	a_prim_range: assert property (p_prim_range)
		else $error("valid angle outside clamp range");

	property p_prim_diag;
		@(posedge mclk) disable iff (!rst_n)
		primary_output_oe && !out_mapped_q |->
			primary_output_level == `AOMS_DIAG_LO;
	endproperty
	a_prim_diag: assert property (p_prim_diag)
		else $error("fault not shown in diagnostic range");

	property p_inv_sum;
		@(posedge mclk) disable iff (!rst_n)
		$past(mode_q) == mode_inverted && out_mapped_q && lo_d2 <= hi_d2 |->
			{1'b0, primary_output_level} + {1'b0, secondary_output_level}
			== {1'b0, lo_d2} + {1'b0, hi_d2};
	endproperty
	a_inv_sum: assert property (p_inv_sum)
		else $error("inverted output not mirrored");

	property p_half;
		@(posedge mclk) disable iff (!rst_n)
		$past(mode_q) == mode_half && out_mapped_q |->
			secondary_output_level == (primary_output_level >> 1);
	endproperty
	a_half: assert property (p_half)
		else $error("half range output wrong");

	property p_cmp_high;
		@(posedge mclk) disable iff (!rst_n)
		mode_q == mode_comparator && !diag_q && angle_q >= thr_q |=>
			secondary_output_level == `AOMS_CMP_HIGH;
	endproperty
	a_cmp_high: assert property (p_cmp_high)
		else $error("comparator not high above threshold");

	property p_err_word;
		@(posedge mclk) disable iff (!rst_n)
		err_q |-> raw_data[`AOMS_ERR_BIT] && raw_data[1:0] == ecode_q;
	endproperty
	a_err_word: assert property (p_err_word)
		else $error("error flag or code missing from word");

	property p_parity;
		@(posedge mclk) disable iff (!rst_n)
		!link_busy ##1 1'b1 |-> (^snap_word[15:8]) && (^snap_word[7:0]);
	endproperty
	a_parity: assert property (p_parity)
		else $error("byte parity is not odd");

	property p_freeze;
		@(posedge mclk) disable iff (!rst_n)
		link_busy ##1 link_busy |-> $stable(snap_word);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("word changed during a frame");

	property p_link_oe;
		@(negedge link_clk) disable iff (cs_n)
		data_oe |-> snap_allow;
	endproperty
	a_link_oe: assert property (p_link_oe)
		else $error("data pin driven outside serial mode");

endmodule : aoms_output_select
`default_nettype wire

// File: verif/aoms_host_model.sv
// Host side of the serial link: frame select, link clock and data pin
`timescale 1ns/1ps
`default_nettype none
module aoms_host_model (
	// link pins towards the device
	output logic      link_clk,
	output logic      cs_n,
	output logic      data_in,
	input  wire logic data_out,
	input  wire logic data_oe
);
	logic [15:0] rx_word;
	logic        oe_any;

	initial begin
		link_clk = 1'b1;
		cs_n = 1'b1;
		data_in = 1'b0;
		rx_word = 16'h0000;
		oe_any = 1'b0;
	end

	task automatic frame(input logic [15:0] tx);
		#3;
		cs_n = 1'b0;
		oe_any = 1'b0;
		#400;
		for (int i = 15; i >= 0; i--) begin
			link_clk = 1'b0;
			data_in = tx[i];
			#6;
			link_clk = 1'b1;
			// undriven pin shows the inverse, never a stale match
			rx_word[i] = data_oe ? data_out : ~data_out;
			oe_any = oe_any | data_oe;
			#6;
		end
		#50;
		cs_n = 1'b1;
		data_in = ~data_in;
		#100;
	endtask : frame
endmodule : aoms_host_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench of the angle output mode select block
`timescale 1ns/1ps
`default_nettype none
module tb_top import aoms_pkg::*;;
	logic          mclk;
	logic          rst_n;
	logic [12:0]   angle_code;
	logic          angle_strobe;
	logic          error_active;
	logic [1:0]    error_code;
	aoms_mode_type mode;
	logic          edge_rate_select;
	logic [12:0]   clamp_lo;
	logic [12:0]   clamp_hi;
	logic [12:0]   thr;
	logic          prog_enable;
	logic [12:0]   p_lvl;
	logic          p_oe;
	logic [12:0]   s_lvl;
	logic          s_oe;
	logic          slow_edge;
	logic          link_clk;
	logic          cs_n;
	logic          data_in;
	logic          data_out;
	logic          data_oe;
	logic [15:0]   prog_word;
	logic          prog_word_valid;
	int            err_total;
	int            samples_checked;
	int            cyc;

	aoms_output_select uut (
		.mclk(mclk), .rst_n(rst_n),
		.angle_code(angle_code), .angle_strobe(angle_strobe),
		.error_active(error_active), .error_code(error_code),
		.output_mode_sel_hi(mode[2]), .output_mode_sel_mid(mode[1]),
		.output_mode_sel_lo(mode[0]), .edge_rate_select(edge_rate_select),
		.clamp_low_level(clamp_lo), .clamp_high_level(clamp_hi),
		.comp_threshold(thr), .prog_enable(prog_enable),
		.primary_output_level(p_lvl), .primary_output_oe(p_oe),
		.secondary_output_level(s_lvl), .secondary_output_oe(s_oe),
		.slow_edge(slow_edge), .link_clk(link_clk), .cs_n(cs_n),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.prog_word(prog_word), .prog_word_valid(prog_word_valid)
	);

	aoms_host_model host (
		.link_clk(link_clk), .cs_n(cs_n), .data_in(data_in),
		.data_out(data_out), .data_oe(data_oe)
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic end_sim();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	// ceiling well above the roughly 1300 cycles the run needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk_lvl(input logic [12:0] got, input logic [12:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_lvl

	task automatic chk_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	// k below 4 raises error code k, 4 means no error
	task automatic setup_in(input aoms_mode_type m, input logic [12:0] a, input int k);
		@(posedge mclk);
		mode <= m;
		angle_code <= a;
		angle_strobe <= 1'b1;
		error_active <= (k < 4);
		error_code <= 2'(k);
		@(posedge mclk);
		angle_strobe <= 1'b0;
		repeat (6) @(posedge mclk);
		@(negedge mclk);
	endtask : setup_in

	task automatic chk_analog();
		logic [25:0] prod;
		logic [12:0] sc;
		logic [12:0] std;
		logic [12:0] sec;
		logic        diag;
		prod = {13'h0000, angle_code} * {13'h0000, clamp_hi - clamp_lo};
		sc = prod[25:13];
		diag = error_active && (error_code != 2'h2);
		std = diag ? 13'h0000 : clamp_lo + sc;
		case (mode)
			mode_inverted: sec = diag ? 13'h1fff : clamp_hi - sc;
			mode_half: sec = std >> 1;
			default: sec = (!diag && angle_code >= thr) ? 13'h1fff : 13'h0000;
		endcase
		chk_bit(p_oe, 1'b1);
		chk_lvl(p_lvl, std);
		if (mode != mode_hiz) chk_lvl(s_lvl, sec);
		chk_bit(s_oe, mode != mode_hiz);
	endtask : chk_analog

	function automatic logic [15:0] exp_word(input logic cpl, input logic [12:0] a, input int k);
		logic [13:0] d;
		d = (k < 4) ? {1'b1, a[12:2], 2'(k)} : {1'b0, a};
		if (cpl) d = ~d;
		return {d[13:7], ~^d[13:7], d[6:0], ~^d[6:0]};
	endfunction : exp_word

	task automatic t_reset();
		@(negedge mclk);
		chk_bit(p_oe, 1'b0);
		chk_bit(s_oe, 1'b0);
		chk_lvl(p_lvl, 13'h0000);
		chk_lvl(s_lvl, 13'h0000);
		chk_bit(slow_edge, 1'b0);
		chk_bit(data_oe, 1'b0);
		chk_word(prog_word, 16'h0000);
	endtask : t_reset

	task automatic t_analog();
		logic [12:0] angles [4];
		angles = '{13'h0000, 13'h0bff, 13'h0c00, 13'h1fff};
		for (int c = 0; c < 2; c++) begin
			@(posedge mclk);
			clamp_lo <= c ? 13'h0800 : 13'h019a;
			clamp_hi <= c ? 13'h1600 : 13'h1e65;
			for (int m = 4; m < 8; m++)
				for (int i = 0; i < 4; i++) begin
					setup_in(aoms_mode_type'(3'(m)), angles[i], 4);
					chk_analog();
				end
		end
	endtask : t_analog

	task automatic t_diag();
		for (int m = 4; m < 7; m++)
			for (int k = 0; k < 4; k++) begin
				setup_in(aoms_mode_type'(3'(m)), 13'h1234, k);
				chk_analog();
			end
	endtask : t_diag

	task automatic t_serial();
		logic [12:0] angles [2];
		angles = '{13'h1a5b, 13'h0003};
		for (int m = 0; m < 2; m++)
			for (int i = 0; i < 2; i++)
				for (int k = 0; k < 5; k++) begin
					setup_in(aoms_mode_type'(3'(m)), angles[i], k);
					chk_bit(p_oe | s_oe, 1'b0);
					host.frame(16'h5555);
					chk_word(host.rx_word, exp_word(m[0], angles[i], k));
					chk_bit(data_oe, 1'b0);
				end
	endtask : t_serial

	task automatic t_reserved();
		for (int m = 2; m < 4; m++) begin
			setup_in(aoms_mode_type'(3'(m)), 13'h0f0f, 4);
			chk_bit(p_oe | s_oe, 1'b0);
			host.frame(16'h5555);
			chk_bit(host.oe_any, 1'b0);
		end
	endtask : t_reserved

	task automatic t_edge();
		for (int v = 1; v >= 0; v--) begin
			@(posedge mclk);
			edge_rate_select <= v[0];
			repeat (3) @(posedge mclk);
			@(negedge mclk);
			chk_bit(slow_edge, v[0]);
		end
	endtask : t_edge

	task automatic t_prog();
		logic [15:0] words [2];
		logic        got;
		words = '{16'hc3a5, 16'h0001};
		setup_in(mode_serial, 13'h0000, 4);
		@(posedge mclk);
		prog_enable <= 1'b1;
		repeat (4) @(posedge mclk);
		for (int i = 0; i < 2; i++) begin
			got = 1'b0;
			fork
				host.frame(words[i]);
				for (int n = 0; n < 60 && !got; n++) begin
					@(posedge mclk);
					#1;
					if (prog_word_valid === 1'b1) got = 1'b1;
				end
			join
			chk_bit(got, 1'b1);
			chk_word(prog_word, words[i]);
			chk_bit(host.oe_any, 1'b0);
		end
		@(posedge mclk);
		prog_enable <= 1'b0;
	endtask : t_prog

	initial begin
		err_total = 0;
		samples_checked = 0;
		cyc = 0;
		rst_n = 1'b0;
		angle_code = 13'h0000;
		angle_strobe = 1'b0;
		error_active = 1'b0;
		error_code = 2'h0;
		mode = mode_inverted;
		edge_rate_select = 1'b1;
		clamp_lo = 13'h019a;
		clamp_hi = 13'h1e65;
		thr = 13'h0c00;
		prog_enable = 1'b0;
		repeat (7) @(posedge mclk);
		t_reset();
		@(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_analog();
		t_diag();
		t_serial();
		t_reserved();
		t_edge();
		t_prog();
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
